// ### rtl/rsgw_pkg.sv
// Constants and types shared by the radio slave gateway core and its serial transmitter.
// Assumes a 125 MHz system clock and a 16-bit plain register port.
package rsgw_pkg;
   // Clock and the 10 ms configuration unit.
   localparam int CLK_PERIOD_NS = 8;
   localparam int UNIT_10MS_NS  = 10_000_000;
   localparam int TICK_CYCLES   = UNIT_10MS_NS / CLK_PERIOD_NS;
   localparam int PRE_W         = 21;

   // Register indices on the plain port.
   localparam logic [3:0] A_DROP  = 4'h0;
   localparam logic [3:0] A_NETID = 4'h1;
   localparam logic [3:0] A_CTS   = 4'h2;
   localparam logic [3:0] A_TMO   = 4'h3;
   localparam logic [3:0] A_OPTS  = 4'h4;
   localparam logic [3:0] A_REDIR = 4'h5;
   localparam logic [3:0] A_DIV1  = 4'h6;
   localparam logic [3:0] A_STAT  = 4'h7;

   // Option bits.
   localparam int OPT_P1_PAR = 0;
   localparam int OPT_P2_PAR = 1;
   localparam int OPT_RMW    = 8;
   localparam int OPT_PROBE  = 9;
   localparam int OPT_REDIR  = 10;

   // Reset values.
   localparam logic [7:0]  DEF_DROP  = 8'h01;
   localparam logic [7:0]  DEF_NETID = 8'h00;
   localparam logic [15:0] DEF_CTS   = 16'h000a;
   localparam logic [15:0] DEF_TMO   = 16'h03e8;
   localparam logic [15:0] DEF_OPTS  = 16'h0003;
   localparam logic [15:0] DEF_REDIR = 16'h0001;
   localparam logic [15:0] DEF_DIV1  = 16'h32dc;

   // Downstream function codes and the online probe register.
   localparam logic [7:0]  FN_RD     = 8'h03;
   localparam logic [7:0]  FN_WR     = 8'h06;
   localparam logic [7:0]  FN_ID     = 8'h11;
   localparam logic [15:0] PROBE_REG = 16'h1ffc;
   localparam logic [7:0]  ONE_REG   = 8'h01;

   // Character framing: 8 data bits, one stop bit.
   localparam logic [3:0] BITS_PAR   = 4'ha;
   localparam logic [3:0] BITS_NOPAR = 4'h9;

   typedef enum logic [1:0] {K_RD, K_WR, K_MWR} rsgw_kind_t;
endpackage

// ### rtl/rsgw_ser_if.sv
// Carrier between the gateway core and its radio-side character transmitter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rsgw_ser_if;
   logic        start;
   logic [7:0]  data;
   logic        par_en;
   logic [15:0] div;
   logic        busy;
   logic        txd;
   modport ctl (output start, data, par_en, div, input busy, txd);
   modport tx  (input start, data, par_en, div, output busy, txd);
endinterface

// ### rtl/rsgw_tx.sv
// Serial character transmitter: start bit, 8 data bits, optional even parity, one stop bit.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
module rsgw_tx
   import rsgw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   rsgw_ser_if.tx   ser
);
   typedef struct packed {
      logic        busy;
      logic        txd;
      logic [9:0]  sh;
      logic [3:0]  left;
      logic [15:0] cnt;
   } rsgw_tx_st_t;

   rsgw_tx_st_t q;
   rsgw_tx_st_t next_q;

   // Frame shape never depends on settings beyond the parity choice.
   always_comb begin
      next_q = q;
      if (!q.busy) begin
         if (ser.start) begin
            next_q.busy = 1'b1;
            next_q.txd  = 1'b0;
            next_q.cnt  = 16'h0000;
            if (ser.par_en) begin
               next_q.sh   = {1'b1, ^ser.data, ser.data};
               next_q.left = BITS_PAR;
            end else begin
               next_q.sh   = {2'b11, ser.data};
               next_q.left = BITS_NOPAR;
            end
         end
      end else if (q.cnt >= ser.div - 16'h0001) begin
         next_q.cnt = 16'h0000;
         if (q.left == 4'h0) begin
            next_q.busy = 1'b0; // Stop bit has fully elapsed.
         end else begin
            next_q.txd  = q.sh[0];
            next_q.sh   = {1'b1, q.sh[9:1]};
            next_q.left = q.left - 4'h1;
         end
      end else begin
         next_q.cnt = q.cnt + 16'h0001;
      end
   end

   // State register; the line idles high.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q     <= '0;
         q.txd <= 1'b1;
         q.sh  <= '1;
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign ser.busy = q.busy;
   assign ser.txd  = q.txd;

   property p_par_len;
      @(posedge clk_sys) disable iff (rst)
      (ce && !q.busy && ser.start && ser.par_en) |=> (q.left == BITS_PAR);
   endproperty
   a_par_len: assert property (p_par_len) else $error("parity frame length wrong");
endmodule // rsgw_tx

// ### rtl/rsgw_core.sv
// Radio slave to downstream master gateway core: settings, translation and push-to-talk.
// Assumes message parsing and downstream framing sit outside; inputs from pins are async.
`timescale 1ns/1ps
// Notes on behaviour
// - Wait at least CTS delay, 10 ms units
// - Raise RTS, start delay, then sample CTS
// - Abandon request after reply timeout, 10 ms units
// - Own station number is the slave address
// - Probe on, redirect off: read 8188 becomes ID
// - Probe off: read 8188 stays plain read
// - Probe and redirect: read redirect register instead
// - Masked write option: read, merge, write back
// - Settings writable only in configuration mode
// - Commit settings on return to run
// - Characters are 8 data, 1 stop
// - Parity per port: even or none
// - Late downstream replies are dropped
module rsgw_core
   import rsgw_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [3:0]       reg_addr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [15:0]      reg_rdata,
   input  wire logic             cfg_switch,
   input  wire logic             cts,
   output logic                  rts,
   output logic                  radio_txd,
   input  wire logic             msg_valid,
   input  wire logic [7:0]       msg_station,
   input  wire rsgw_pkg::rsgw_kind_t msg_kind,
   input  wire logic [15:0]      msg_reg,
   input  wire logic [7:0]       msg_cnt,
   input  wire logic [15:0]      msg_data,
   input  wire logic [15:0]      msg_mask,
   output logic                  msg_ready,
   output logic                  mb_req,
   output logic      [7:0]       mb_func,
   output logic      [15:0]      mb_reg,
   output logic      [15:0]      mb_data,
   output logic      [7:0]       mb_slave,
   output logic                  mb_parity_even,
   input  wire logic             mb_rsp_valid,
   input  wire logic [15:0]      mb_rsp_data,
   output logic                  nv_commit,
   output logic      [7:0]       net_id
);
   typedef enum {S_IDLE, S_WAIT, S_CTS, S_GAP, S_DRAIN} rsgw_state_t;

   typedef struct packed {
      rsgw_state_t state;
      logic        cts_s1, cts_s2, cfg_s1, cfg_s2, cfg_d;
      logic [7:0]  drop, netid, tmo_cnt;
      logic [15:0] cts_units, tmo_units, opts, redir, div1;
      logic [PRE_W-1:0] pre;
      logic        tick;
      logic [15:0] tmr, mask, wdat, rsp, rdata;
      logic        rmw, byte_lo, rts, msg_ready, mb_req, nv_commit, tx_start, hit;
      logic [7:0]  mb_func, tx_data;
      logic [15:0] mb_reg, mb_data;
   } rsgw_st_t;

   rsgw_st_t   q;
   rsgw_st_t   next_q;
   rsgw_ser_if ser ();

   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

   // Next-state logic for settings, translation and the push-to-talk sequence.
   always_comb begin
      next_q = q;
      next_q.nv_commit = 1'b0;
      next_q.mb_req    = 1'b0;
      next_q.tx_start  = 1'b0;
      next_q.tick      = 1'b0;
      // Pin synchronisers; only the second stage is used by logic.
      next_q.cts_s1 = cts;
      next_q.cts_s2 = q.cts_s1;
      next_q.cfg_s1 = cfg_switch;
      next_q.cfg_s2 = q.cfg_s1;
      next_q.cfg_d  = q.cfg_s2;
      // Leaving configuration mode asks the store to keep the settings.
      next_q.nv_commit = q.cfg_d & ~q.cfg_s2;

      // Free 10 ms prescaler; restarted when a timed wait begins so units are whole.
      if (q.pre >= PRE_LAST) begin
         next_q.pre  = '0;
         next_q.tick = 1'b1;
      end else begin
         next_q.pre = q.pre + 1'b1;
      end

      // Register read: data appear in the next cycle; unmapped reads give zero.
      if (reg_rd) begin
         if (reg_addr == A_DROP) begin
            next_q.rdata = {8'h00, q.drop};
         end else if (reg_addr == A_NETID) begin
            next_q.rdata = {8'h00, q.netid};
         end else if (reg_addr == A_CTS) begin
            next_q.rdata = q.cts_units;
         end else if (reg_addr == A_TMO) begin
            next_q.rdata = q.tmo_units;
         end else if (reg_addr == A_OPTS) begin
            next_q.rdata = q.opts;
         end else if (reg_addr == A_REDIR) begin
            next_q.rdata = q.redir;
         end else if (reg_addr == A_DIV1) begin
            next_q.rdata = q.div1;
         end else if (reg_addr == A_STAT) begin
            next_q.rdata = {5'h00, q.cfg_s2, q.state != S_IDLE, q.rts, q.tmo_cnt};
         end else begin
            next_q.rdata = 16'h0000;
         end
      end

      // Settings change only in configuration mode, so a running link never sees them move.
      if (reg_wr && q.cfg_s2) begin
         if (reg_addr == A_DROP) begin
            next_q.drop = reg_wdata[7:0];
         end else if (reg_addr == A_NETID) begin
            next_q.netid = reg_wdata[7:0];
         end else if (reg_addr == A_CTS) begin
            next_q.cts_units = reg_wdata;
         end else if (reg_addr == A_TMO) begin
            next_q.tmo_units = reg_wdata;
         end else if (reg_addr == A_OPTS) begin
            next_q.opts = reg_wdata;
         end else if (reg_addr == A_REDIR) begin
            next_q.redir = reg_wdata;
         end else if (reg_addr == A_DIV1) begin
            next_q.div1 = reg_wdata;
         end
      end

      // Translation and reply sequence.
      case (q.state)
         S_IDLE: begin
            // Only messages for our own station start a translation.
            if (msg_valid && !q.cfg_s2 && msg_station == q.drop) begin
               next_q.hit    = (msg_kind == K_RD) && (msg_reg == PROBE_REG)
                               && (msg_cnt == ONE_REG);
               next_q.mb_req = 1'b1;
               next_q.mb_reg = msg_reg;
               next_q.mb_data = msg_data;
               next_q.wdat   = msg_data;
               next_q.mask   = msg_mask;
               next_q.rmw    = 1'b0;
               next_q.tmr    = 16'h0000;
               next_q.pre    = '0;
               next_q.tick   = 1'b0; // A wrap in this cycle must not count as a whole unit.
               next_q.state  = S_WAIT;
               if (msg_kind == K_RD) begin
                  next_q.mb_func = FN_RD;
                  if (next_q.hit && q.opts[OPT_PROBE]) begin
                     if (q.opts[OPT_REDIR]) begin
                        next_q.mb_reg = q.redir;
                     end else begin
                        next_q.mb_func = FN_ID;
                     end
                  end
               end else if (msg_kind == K_MWR && q.opts[OPT_RMW]) begin
                  next_q.mb_func = FN_RD;
                  next_q.rmw     = 1'b1;
               end else begin
                  next_q.mb_func = FN_WR;
               end
            end
         end
         S_WAIT: begin
            if (mb_rsp_valid) begin
               next_q.rsp = mb_rsp_data;
               next_q.tmr = 16'h0000;
               next_q.pre = '0;
               next_q.tick = 1'b0; // Keeps the CTS delay from starting one unit short.
               if (q.rmw) begin
                  // Merge the old word under the mask, then write it back.
                  next_q.rmw     = 1'b0;
                  next_q.mb_req  = 1'b1;
                  next_q.mb_func = FN_WR;
                  next_q.mb_data = (mb_rsp_data & ~q.mask) | (q.wdat & q.mask);
               end else begin
                  next_q.rts   = 1'b1;
                  next_q.state = S_CTS;
               end
            end else if (q.tmr >= q.tmo_units) begin
               next_q.state   = S_IDLE; // Idle ignores replies.
               next_q.tmo_cnt = q.tmo_cnt + 8'h01;
            end else if (q.tick) begin
               next_q.tmr = q.tmr + 16'h0001;
            end
         end
         S_CTS: begin
            // CTS is looked at only once the delay has run out.
            if (q.tmr >= q.cts_units && q.cts_s2) begin
               next_q.tx_data  = q.rsp[15:8];
               next_q.tx_start = 1'b1;
               next_q.byte_lo  = 1'b0;
               next_q.state    = S_GAP;
            end else if (q.tick && q.tmr < q.cts_units) begin
               next_q.tmr = q.tmr + 16'h0001;
            end
         end
         S_GAP: begin
            // One cycle for the transmitter to show busy.
            next_q.state = S_DRAIN;
         end
         S_DRAIN: begin
            if (!ser.busy) begin
               if (!q.byte_lo) begin
                  next_q.byte_lo  = 1'b1;
                  next_q.tx_data  = q.rsp[7:0];
                  next_q.tx_start = 1'b1;
                  next_q.state    = S_GAP;
               end else begin
                  next_q.rts   = 1'b0;
                  next_q.state = S_IDLE;
               end
            end
         end
         default: begin
            next_q.state = S_IDLE;
         end
      endcase
      next_q.msg_ready = (next_q.state == S_IDLE);
   end

   // State register with asynchronous reset to the default settings.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q           <= '0;
         q.drop      <= DEF_DROP;
         q.netid     <= DEF_NETID;
         q.cts_units <= DEF_CTS;
         q.tmo_units <= DEF_TMO;
         q.opts      <= DEF_OPTS;
         q.redir     <= DEF_REDIR;
         q.div1      <= DEF_DIV1;
         q.msg_ready <= 1'b1;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // Radio-side character transmitter.
   assign ser.start  = q.tx_start;
   assign ser.data   = q.tx_data;
   assign ser.par_en = q.opts[OPT_P1_PAR];
   assign ser.div    = q.div1;

   rsgw_tx u_tx (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .ser     (ser)
   );

   assign reg_rdata      = q.rdata;
   assign rts            = q.rts;
   assign radio_txd      = ser.txd;
   assign msg_ready      = q.msg_ready;
   assign mb_req         = q.mb_req;
   assign mb_func        = q.mb_func;
   assign mb_reg         = q.mb_reg;
   assign mb_data        = q.mb_data;
   assign mb_slave       = q.drop;
   assign mb_parity_even = q.opts[OPT_P2_PAR];
   assign nv_commit      = q.nv_commit;
   assign net_id         = q.netid;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_first_char;
      q.tx_start && !q.byte_lo;
   endsequence
   property p_cts_wait;
      s_first_char |-> (q.tmr >= q.cts_units) && q.rts;
   endproperty
   a_cts_wait: assert property (p_cts_wait) else $error("sent before CTS delay");
   property p_cts_seen;
      s_first_char |-> $past(q.cts_s2) && (q.state == S_GAP);
   endproperty
   a_cts_seen: assert property (p_cts_seen) else $error("sent without CTS");
   property p_tmo;
      (ce && q.state == S_WAIT && !mb_rsp_valid && q.tmr >= q.tmo_units) |=> q.state == S_IDLE;
   endproperty
   a_tmo: assert property (p_tmo) else $error("reply timeout not taken");
   property p_station;
      (ce && q.state == S_IDLE && msg_station != q.drop) |=> !q.mb_req;
   endproperty
   a_station: assert property (p_station) else $error("foreign station accepted");
   property p_probe_id;
      (q.mb_req && q.mb_func == FN_ID) |-> q.hit && q.opts[OPT_PROBE] && !q.opts[OPT_REDIR];
   endproperty
   a_probe_id: assert property (p_probe_id) else $error("bad ID substitution");
   property p_probe_off;
      (q.mb_req && q.hit && !q.opts[OPT_PROBE]) |-> q.mb_func == FN_RD && q.mb_reg == PROBE_REG;
   endproperty
   a_probe_off: assert property (p_probe_off) else $error("probe read changed");
   property p_redir;
      (q.mb_req && q.hit && q.opts[OPT_PROBE] && q.opts[OPT_REDIR]) |-> q.mb_reg == q.redir;
   endproperty
   a_redir: assert property (p_redir) else $error("redirect not applied");
   property p_merge;
      (q.mb_req && q.state == S_WAIT && $past(q.rmw) && !q.rmw)
         |-> q.mb_data == ((q.rsp & ~q.mask) | (q.wdat & q.mask));
   endproperty
   a_merge: assert property (p_merge) else $error("masked merge wrong");
   property p_cfg_lock;
      (ce && reg_wr && !q.cfg_s2) |=> $stable(q.drop) && $stable(q.opts);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("write in run mode");
   property p_commit;
      ($fell(q.cfg_s2) && ce) |=> q.nv_commit;
   endproperty
   a_commit: assert property (p_commit) else $error("no commit on run");
   property p_late;
      (ce && q.state == S_IDLE && mb_rsp_valid) |=> !q.rts && !q.tx_start;
   endproperty
   a_late: assert property (p_late) else $error("late reply forwarded");
   property p_rts_drop;
      $fell(q.rts) |-> !ser.busy && q.byte_lo;
   endproperty
   a_rts_drop: assert property (p_rts_drop) else $error("RTS dropped early");
endmodule // rsgw_core

// ### verification/rsgw_far_model.sv
// Far-side model: a push-to-talk modem that answers RTS with CTS, and a downstream slave.
// Assumes the core's clock, one request outstanding, and a bench that sets the reply delay.
`timescale 1ns/1ps
module rsgw_far_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        rts,
   output logic             cts,
   input  wire logic        mb_req,
   input  wire logic [7:0]  mb_slave,
   output logic             mb_rsp_valid,
   output logic [15:0]      mb_rsp_data,
   input  wire logic        rsp_en,
   input  wire logic [15:0] rsp_lat,
   input  wire logic [15:0] rsp_word,
   input  wire logic [7:0]  own_addr,
   output int               req_cnt
);
   logic [3:0]  cts_cnt;
   logic [15:0] wait_cnt;
   logic        pend;

   // The modem raises CTS soon after RTS, well before the core may look at it.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst || !rts) begin
         cts     <= 1'b0;
         cts_cnt <= 4'h0;
      end else if (cts_cnt != 4'h3) begin
         cts_cnt <= cts_cnt + 4'h1;
      end else begin
         cts <= 1'b1;
      end
   end

   // The slave answers only its own address; idle data toggles so stale words never match.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend         <= 1'b0;
         wait_cnt     <= 16'h0000;
         mb_rsp_valid <= 1'b0;
         mb_rsp_data  <= 16'h0000;
         req_cnt      <= 0;
      end else begin
         mb_rsp_valid <= 1'b0;
         mb_rsp_data  <= ~mb_rsp_data;
         if (mb_req) begin
            req_cnt <= req_cnt + 1;
         end
         if (mb_req && rsp_en && mb_slave == own_addr) begin
            pend     <= 1'b1;
            wait_cnt <= rsp_lat;
         end else if (pend && wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
         end else if (pend) begin
            pend         <= 1'b0;
            mb_rsp_valid <= 1'b1;
            mb_rsp_data  <= rsp_word;
         end
      end
   end
endmodule // rsgw_far_model

// ### verification/radio_slave_modbus_gateway_config_tb_top.sv
// Self-checking bench for the gateway core with the far-side model on its ports.
// Assumes a shortened 10 ms tick and a bit divisor of 4 so that frames stay short.
`timescale 1ns/1ps
module radio_slave_modbus_gateway_config_tb_top;
   import rsgw_pkg::*;
   localparam int TICK = 20;
   localparam int CTSU = 2;
   localparam int TMOU = 5;
   logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, cfg_switch = 0, msg_valid = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, msg_reg = 16'h0000, msg_data = 16'h0000;
   logic [15:0] msg_mask = 16'h0000, rsp_lat = 16'h0002, rsp_word = 16'ha55a;
   logic [7:0]  msg_station = 8'h01, msg_cnt = 8'h01;
   rsgw_kind_t  msg_kind = K_RD;
   logic        rsp_en = 1;
   logic [15:0] reg_rdata, mb_reg, mb_data, mb_rsp_data;
   logic [7:0]  mb_func, mb_slave, net_id;
   logic        cts, rts, radio_txd, msg_ready, mb_req, mb_parity_even, mb_rsp_valid, nv_commit;
   int          req_cnt, err_total = 0, checks_done = 0;

   rsgw_core #(.TICK_CYC(TICK)) dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cfg_switch(cfg_switch), .cts(cts), .rts(rts),
      .radio_txd(radio_txd), .msg_valid(msg_valid), .msg_station(msg_station),
      .msg_kind(msg_kind), .msg_reg(msg_reg), .msg_cnt(msg_cnt), .msg_data(msg_data),
      .msg_mask(msg_mask), .msg_ready(msg_ready), .mb_req(mb_req), .mb_func(mb_func),
      .mb_reg(mb_reg), .mb_data(mb_data), .mb_slave(mb_slave),
      .mb_parity_even(mb_parity_even), .mb_rsp_valid(mb_rsp_valid),
      .mb_rsp_data(mb_rsp_data), .nv_commit(nv_commit), .net_id(net_id));
   rsgw_far_model far (.clk_sys(clk_sys), .rst(rst), .rts(rts), .cts(cts), .mb_req(mb_req),
      .mb_slave(mb_slave), .mb_rsp_valid(mb_rsp_valid), .mb_rsp_data(mb_rsp_data),
      .rsp_en(rsp_en), .rsp_lat(rsp_lat), .rsp_word(rsp_word), .own_addr(8'h01),
      .req_cnt(req_cnt));

   // Free-running 125 MHz clock.
   always #4 clk_sys = ~clk_sys;

   // Shared comparison; an unknown never counts as a match.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data are taken in the one cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Leaving configuration mode must store the settings with one pulse.
   task automatic set_cfg(input logic on);
      int n;
      @(posedge clk_sys);
      cfg_switch <= on;
      n = 0;
      while (on == 1'b0 && nv_commit !== 1'b1 && n < 12) begin
         tick(1);
         n++;
      end
      if (on == 1'b0) chk("commit", n < 12, 1);
      tick(4);
   endtask

   task automatic send(input logic [7:0] st, input rsgw_kind_t k, input logic [15:0] r,
                       input logic [15:0] d, input logic [15:0] m);
      @(posedge clk_sys);
      msg_valid <= 1'b1;
      msg_station <= st;
      msg_kind <= k;
      msg_reg <= r;
      msg_data <= d;
      msg_mask <= m;
      @(posedge clk_sys);
      msg_valid <= 1'b0;
   endtask

   // The request pulse stands one cycle, so the current cycle is looked at first.
   task automatic wait_req(output logic ok);
      int n;
      n = 0;
      #1;
      ok = (mb_req === 1'b1);
      while (!ok && n < 60) begin
         tick(1);
         ok = (mb_req === 1'b1);
         n++;
      end
   endtask

   // Decodes one character from the falling edge of its start bit, sampling mid-bit.
   task automatic get_byte(input logic par, output logic [7:0] b);
      tick(2);
      chk("start bit", radio_txd, 0);
      for (int i = 0; i < 8; i++) begin
         tick(4);
         b[i] = radio_txd;
      end
      if (par) begin
         tick(4);
         chk("parity bit", radio_txd, ^b);
      end
      tick(4);
      chk("stop bit", radio_txd, 1);
   endtask

   task automatic wait_txd_low(output int n);
      n = 0;
      while (radio_txd !== 1'b0 && n < 400) begin
         tick(1);
         n++;
      end
   endtask

   // Waits for the reply transmission and checks delay, bytes and the release of RTS.
   task automatic finish_reply(input logic [15:0] w, input logic par);
      logic [7:0] hi, lo;
      int n;
      n = 0;
      while (rts !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk("rts raised", rts, 1);
      wait_txd_low(n);
      chk("cts delay", n >= CTSU * TICK, 1);
      get_byte(par, hi);
      wait_txd_low(n);
      get_byte(par, lo);
      chk("reply word", {hi, lo}, w);
      chk("rts held", rts, 1);
      tick(8);
      chk("rts released", rts, 0);
      chk("ready again", msg_ready, 1);
   endtask

   task automatic t_reset_values;
      logic [15:0] d;
      logic [15:0] dv [0:6];
      dv = '{{8'h00, DEF_DROP}, {8'h00, DEF_NETID}, DEF_CTS, DEF_TMO, DEF_OPTS, DEF_REDIR,
             DEF_DIV1};
      chk("idle line", {rts, radio_txd, msg_ready, mb_slave}, {3'b011, 8'h01});
      set_cfg(1);
      for (int i = 0; i < 7; i++) begin
         rd(4'(i), d);
         chk("reset value", d, dv[i]);
      end
      rd(4'h9, d);
      chk("unmapped read", d, 0);
      wr(A_CTS, 16'(CTSU));
      wr(A_TMO, 16'(TMOU));
      wr(A_DIV1, 16'h0004);
      wr(A_REDIR, 16'h0007);
      wr(A_NETID, 16'h002a);
      set_cfg(0);
      chk("network identifier", net_id, 8'h2a);
   endtask

   // Run-mode writes and foreign stations must have no effect.
   task automatic t_run_mode;
      logic [15:0] d;
      logic ok;
      wr(A_DROP, 16'h0009);
      rd(A_DROP, d);
      chk("run write", d, 16'h0001);
      chk("slave address", mb_slave, 8'h01);
      send(8'h02, K_RD, 16'h0000, 16'h0000, 16'h0000);
      wait_req(ok);
      chk("foreign station", ok, 0);
   endtask

   // Reads of the online probe register under all three option settings.
   task automatic t_probe;
      logic [15:0] ov [0:2];
      logic [23:0] ev [0:2];
      logic ok;
      ov = '{16'h0000, 16'h0203, 16'h0601};
      ev = '{{FN_RD, PROBE_REG}, {FN_ID, PROBE_REG}, {FN_RD, 16'h0007}};
      for (int i = 0; i < 3; i++) begin
         set_cfg(1);
         wr(A_OPTS, ov[i]);
         set_cfg(0);
         chk("port 2 parity", mb_parity_even, ov[i][1]);
         send(8'h01, K_RD, PROBE_REG, 16'h0000, 16'h0000);
         wait_req(ok);
         chk("probe request", {mb_func, mb_reg}, ev[i]);
         chk("busy", msg_ready, 0);
         finish_reply(rsp_word, ov[i][0]);
      end
   endtask

   task automatic t_merge;
      logic ok;
      set_cfg(1);
      wr(A_OPTS, 16'h0103);
      set_cfg(0);
      rsp_lat <= 16'd30;
      rsp_word <= 16'hf0f0;
      send(8'h01, K_MWR, 16'h0005, 16'h1234, 16'h00ff);
      wait_req(ok);
      chk("merge read", {ok, mb_func, mb_reg}, {1'b1, FN_RD, 16'h0005});
      tick(1);
      wait_req(ok);
      chk("merge write", {ok, mb_func, mb_data}, {1'b1, FN_WR, 16'hf034});
      finish_reply(16'hf0f0, 1'b1);
      chk("request count", req_cnt, 5);
   endtask

   // A reply later than the timeout is dropped and the request abandoned.
   task automatic t_timeout;
      logic ok;
      logic [15:0] d;
      int n;
      rsp_lat <= 16'd200;
      send(8'h01, K_RD, 16'h000a, 16'h0000, 16'h0000);
      wait_req(ok);
      n = 0;
      while (msg_ready !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      chk("timeout span", n >= TMOU * TICK - 2 && n <= TMOU * TICK + TICK, 1);
      n = 0;
      repeat (250) begin
         tick(1);
         n += (rts !== 1'b0);
      end
      chk("late reply dropped", n, 0);
      rd(A_STAT, d);
      chk("timeout count", d[7:0], 8'h01);
   endtask

   task report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Main sequence after the reset is released.
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      tick(2);
      t_reset_values();
      t_run_mode();
      t_probe();
      t_merge();
      t_timeout();
      report_and_stop();
   end

   // Watchdog: the tests need well under two thousand cycles, so this leaves ample margin.
   initial begin
      #400000;
      err_total++;
      report_and_stop();
   end
endmodule // radio_slave_modbus_gateway_config_tb_top
